/* File: ffrh_pkg.sv */
package ffrh_pkg;
   // ==========================================
   // Widths
   localparam int NCH = 2;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int CNT_W = WORD_W + 1;
   localparam int FIFO_W = 1 + 1 + BYTE_W;
   localparam int FIFO_DEPTH_DEF = 8;
   // ==========================================
   // Stream entry layout: channel, last flag, byte
   localparam int FLD_CH = BYTE_W + 1;
   localparam int FLD_LAST = BYTE_W;
   // ==========================================
   // Control word values
   localparam logic [WORD_W-1:0] CHAN_FIRST = 16'h0001;
   localparam logic [WORD_W-1:0] CHAN_SECOND = 16'h0002;
   localparam logic [WORD_W-1:0] RES_OK = 16'h0000;
   localparam logic [WORD_W-1:0] ERR_SIMUL = 16'h7FF0;
   localparam logic [WORD_W-1:0] ERR_PROTO = 16'h7FF2;
   localparam logic [WORD_W-1:0] ERR_CHAN_DEF = 16'h7FFE;
   localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 17'h0_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 17'h0_0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 17'h1_FFFF;
   // ==========================================
   // Types
   typedef enum logic [3:0] {
      OP_RECEIVE, OP_CHAN_SET, OP_USER_REG, OP_BUF_RECV, OP_PUSH_SEND,
      OP_BIDIR_SEND, OP_BIDIR_RECV, OP_PROTOCOL, OP_OTHER
   } ffrh_op_t;
   typedef enum logic [1:0] {DS_IDLE, DS_PEND, DS_SHOW} ffrh_done_t;
   // ==========================================
   // Helpers
   function automatic logic is_proto(ffrh_op_t k);
      return (k == OP_PUSH_SEND) || (k == OP_BIDIR_SEND) || (k == OP_BIDIR_RECV) || (k == OP_PROTOCOL);
   endfunction
   function automatic logic chan_ok(logic [WORD_W-1:0] v);
      return (v == CHAN_FIRST) || (v == CHAN_SECOND);
   endfunction
   function automatic logic chan_idx(logic [WORD_W-1:0] v);
      return v == CHAN_SECOND;
   endfunction
   // Capacity in the configured unit; byte mode holds two bytes per word
   function automatic logic [CNT_W-1:0] cap_units(logic [WORD_W-1:0] allow, logic bu);
      return bu ? {allow, 1'b0} : {1'b0, allow};
   endfunction
endpackage

/* File: ffrh_stream_if.sv */
`timescale 1ns/1ns
interface ffrh_stream_if;
   import ffrh_pkg::*;
   logic [FIFO_W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

/* File: ffrh_fifo.sv */
`timescale 1ns/1ns
module ffrh_fifo
   import ffrh_pkg::*;
#(
   parameter int W = FIFO_W,
   parameter int D = FIFO_DEPTH_DEF
) (
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   input logic ce,
   // Stream sides
   ffrh_stream_if.snk wr,
   ffrh_stream_if.src rd
);
   localparam int AW = $clog2(D);
   initial begin
      if (D < 2 || (1 << AW) != D || W != FIFO_W) begin
         $error("ffrh_fifo: depth must be a power of two and width must match the entry");
      end
   end
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   logic push;
   logic load;
   logic [AW:0] next_cnt;
   // ==========================================
   // Output register stage keeps read data straight off a flop
   assign push = wr.valid && wr.ready;
   assign load = (cnt != '0) && (!rd.valid || rd.ready);
   assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(load);
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wp] <= wr.data;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         wr.ready <= 1'b0;
         rd.valid <= 1'b0;
         rd.data <= '0;
      end else if (ce) begin
         wp <= wp + AW'(push);
         rp <= rp + AW'(load);
         cnt <= next_cnt;
         wr.ready <= next_cnt != (AW+1)'(D);
         if (load) begin
            rd.data <= mem[rp];
            rd.valid <= 1'b1;
         end else if (rd.ready) begin
            rd.valid <= 1'b0;
         end
      end
   end
   a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst)
      cnt <= (AW+1)'(D)) else $error("fifo count above depth");
   a_fifo_full: assert property (@(posedge clk) disable iff (sys_rst)
      (cnt == (AW+1)'(D)) |-> !wr.ready) else $error("fifo takes data while full");
endmodule

/* File: ffrh_guard.sv */
`timescale 1ns/1ns
module ffrh_guard
   import ffrh_pkg::*;
(
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   input logic ce,
   // Issue and end of instructions
   input logic issue,
   input ffrh_op_t kind,
   input logic ch,
   input logic end_v,
   input ffrh_op_t end_kind,
   input logic end_ch,
   input logic [NCH-1:0] rcv_act,
   // Decisions
   output logic rcv_go,
   output logic rcv_drop,
   output logic [WORD_W-1:0] rcv_code,
   output logic [WORD_W-1:0] ans_code
);
   logic [NCH-1:0] ureg_act;
   logic [NCH-1:0] proto_act;
   // ==========================================
   // Conflict decode, each channel judged on its own flags only
   always_comb begin
      rcv_go = 1'b0;
      rcv_drop = 1'b0;
      rcv_code = RES_OK;
      ans_code = RES_OK;
      if (kind == OP_RECEIVE) begin
         if (rcv_act[ch]) begin
            rcv_drop = 1'b1; // R11
         end else if (proto_act[ch]) begin
            rcv_code = ERR_PROTO; // R16
         end else if (ureg_act[ch]) begin
            rcv_code = ERR_SIMUL; // R15
         end else begin
            rcv_go = 1'b1; // R12
         end
      end else if (rcv_act[ch]) begin
         if (kind == OP_CHAN_SET || kind == OP_USER_REG) begin
            ans_code = ERR_SIMUL; // R13 R15
         end else if (is_proto(kind)) begin
            ans_code = ERR_PROTO; // R16
         end
      end
   end
   // ==========================================
   // Activity of the competing instructions; a start beats an end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ureg_act <= '0;
         proto_act <= '0;
      end else if (ce) begin
         for (int i = 0; i < NCH; i++) begin
            if (issue && ch == 1'(i) && ans_code == RES_OK && kind == OP_USER_REG) begin
               ureg_act[i] <= 1'b1;
            end else if (end_v && end_ch == 1'(i) && end_kind == OP_USER_REG) begin
               ureg_act[i] <= 1'b0;
            end
            if (issue && ch == 1'(i) && ans_code == RES_OK && is_proto(kind)) begin
               proto_act[i] <= 1'b1;
            end else if (end_v && end_ch == 1'(i) && is_proto(end_kind)) begin
               proto_act[i] <= 1'b0;
            end
         end
      end
   end
   a_busy_ignored: assert property (@(posedge clk) disable iff (sys_rst)
      (kind == OP_RECEIVE && rcv_act[ch]) |-> (!rcv_go && rcv_code == RES_OK)) // R11
      else $error("receive taken on a busy channel");
endmodule

/* File: ffrh_top.sv */
`timescale 1ns/1ns
// Overview of operation
// R1: First control word picks the channel, 1 or 2.
// R2: Result word gets zero on success, an error code on failure.
// R3: Count word gets the number of items received when finished.
// R4: Count is in bytes or words as the unit setting selects.
// R5: Program sets the allowed word count, at least one, beforehand.
// R6: Received bytes go to consecutive destination words from the head address.
// R7: Data beyond the allowed size is dropped; completion is still normal.
// R8: After truncation the allowed size is reported as the count.
// R9: Program issues the receive in level form only, never pulsed.
// R10: Program issues the receive only while read request is on.
// R11: A second receive on a busy channel is ignored.
// R12: Different channels run at the same time without conflict.
// R13: Channel setting during an active receive fails with 7FF0.
// R14: Program never mixes receive and interrupt buffer receive on a channel.
// R15: Receive and user registration overlapping: the later one fails, 7FF0.
// R16: Other protocol families on the channel give error 7FF2.
// R17: Completion bit on at a scan end, off at the next.
// R18: Status bit off when normal, on with completion when abnormal.
// R19: Error code is in the result word when status bit turns on.
// R20: Operation error sets the system error flag and code word.
// R21: Program issues the receive only while the completion bit is off.
// R22: Result and count are written before the completion bit turns on.
module ffrh_top
   import ffrh_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter logic [WORD_W-1:0] ERR_CHAN = ERR_CHAN_DEF
) (
   // Clock, reset, enable
   input logic clk,
   input logic sys_rst,
   input logic ce,
   // Instruction issue from the program
   input logic op_issue,
   input ffrh_op_t op_kind,
   input logic [WORD_W-1:0] op_chan,
   input logic [WORD_W-1:0] op_allow,
   input logic [WORD_W-1:0] op_head,
   input logic op_end,
   input ffrh_op_t op_end_kind,
   input logic [WORD_W-1:0] op_end_chan,
   output logic op_ans_valid,
   output logic [WORD_W-1:0] op_ans_code,
   // Configuration and scan timing
   input logic byte_units,
   input logic scan_end,
   input logic sys_err_clr,
   // Received serial data
   input logic rx_valid,
   input logic [BYTE_W-1:0] rx_data,
   input logic rx_chan,
   input logic rx_last,
   output logic rx_ready,
   // Destination device writes
   input logic dev_hold,
   output logic dev_we,
   output logic [WORD_W-1:0] dev_addr,
   output logic [WORD_W-1:0] dev_data,
   // Per channel results
   output logic [NCH-1:0][WORD_W-1:0] result_word,
   output logic [NCH-1:0][WORD_W-1:0] count_word,
   output logic [NCH-1:0] completion_bit,
   output logic [NCH-1:0] completion_status,
   // System error
   output logic system_error_flag,
   output logic [WORD_W-1:0] system_error_code_word
);
   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("ffrh_top: fifo depth too small");
      end
   end
   // ==========================================
   // Receive fifo
   ffrh_stream_if push_if();
   ffrh_stream_if pop_if();
   assign push_if.valid = rx_valid && ce;
   assign push_if.data = {rx_chan, rx_last, rx_data};
   assign rx_ready = push_if.ready;
   // Destination back-pressure reaches the serial side through the fifo
   assign pop_if.ready = ce && !dev_hold;
   ffrh_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .wr(push_if),
      .rd(pop_if)
   );
   // ==========================================
   // Issue decode and arbitration
   logic iss_ok;
   logic iss_ch;
   logic g_go;
   logic g_drop;
   logic [WORD_W-1:0] g_code;
   logic [WORD_W-1:0] g_ans;
   logic [NCH-1:0] act;
   logic acc;
   logic rej;
   assign iss_ok = op_issue && chan_ok(op_chan); // R1
   assign iss_ch = chan_idx(op_chan);
   assign acc = iss_ok && op_kind == OP_RECEIVE && g_go;
   assign rej = iss_ok && op_kind == OP_RECEIVE && !g_go && !g_drop;
   ffrh_guard u_guard (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .issue(iss_ok),
      .kind(op_kind),
      .ch(iss_ch),
      .end_v(op_end && chan_ok(op_end_chan)),
      .end_kind(op_end_kind),
      .end_ch(chan_idx(op_end_chan)),
      .rcv_act(act),
      .rcv_go(g_go),
      .rcv_drop(g_drop),
      .rcv_code(g_code),
      .ans_code(g_ans)
   );
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         op_ans_valid <= 1'b0;
         op_ans_code <= RES_OK;
      end else if (ce) begin
         op_ans_valid <= iss_ok && op_kind != OP_RECEIVE;
         op_ans_code <= g_ans; // R13
      end
   end
   // ==========================================
   // Per channel receive engines
   logic [NCH-1:0][WORD_W-1:0] head;
   logic [NCH-1:0][WORD_W-1:0] allow;
   logic [NCH-1:0][CNT_W-1:0] woff;
   logic [NCH-1:0][CNT_W-1:0] nbytes;
   logic [NCH-1:0] phase;
   logic [NCH-1:0][BYTE_W-1:0] lo;
   logic pop;
   logic e_ch;
   logic e_last;
   logic [BYTE_W-1:0] e_byte;
   logic hit;
   logic wr_ev;
   logic [NCH-1:0] fin;
   logic [CNT_W-1:0] nb_now;
   assign pop = pop_if.valid && pop_if.ready;
   assign e_ch = pop_if.data[FLD_CH];
   assign e_last = pop_if.data[FLD_LAST];
   assign e_byte = pop_if.data[BYTE_W-1:0];
   // Bytes for a channel with no receive pending are consumed and lost
   assign hit = pop && act[e_ch];
   assign wr_ev = hit && (phase[e_ch] || e_last);
   assign nb_now = (nbytes[e_ch] == CNT_MAX) ? CNT_MAX : nbytes[e_ch] + CNT_ONE;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         fin[i] = (hit && e_last && e_ch == 1'(i)) || (rej && iss_ch == 1'(i));
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         act <= '0;
         head <= '0;
         allow <= '0;
         woff <= '0;
         nbytes <= '0;
         phase <= '0;
         lo <= '0;
      end else if (ce) begin
         for (int i = 0; i < NCH; i++) begin
            if (acc && iss_ch == 1'(i)) begin
               act[i] <= 1'b1; // R12
               head[i] <= op_head; // R6
               allow[i] <= op_allow; // R5
               woff[i] <= CNT_ZERO;
               nbytes[i] <= CNT_ZERO;
               phase[i] <= 1'b0;
            end else if (hit && e_ch == 1'(i)) begin
               phase[i] <= !phase[i];
               lo[i] <= e_byte;
               nbytes[i] <= nb_now;
               if ((phase[i] || e_last) && woff[i] != CNT_MAX) begin
                  woff[i] <= woff[i] + CNT_ONE; // R6
               end
               if (e_last) begin
                  act[i] <= 1'b0;
               end
            end
         end
      end
   end
   // ==========================================
   // Destination write port, low byte first in each word
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dev_we <= 1'b0;
         dev_addr <= '0;
         dev_data <= '0;
      end else if (ce) begin
         dev_we <= wr_ev && woff[e_ch] < {1'b0, allow[e_ch]}; // R7
         dev_addr <= head[e_ch] + woff[e_ch][WORD_W-1:0]; // R6
         dev_data <= phase[e_ch] ? {e_byte, lo[e_ch]} : {ZERO_BYTE, e_byte};
      end
   end
   // ==========================================
   // Result and count words
   function automatic logic [WORD_W-1:0] count_units(logic [CNT_W-1:0] nb, logic [WORD_W-1:0] lim, logic bu);
      logic [CNT_W-1:0] units;
      logic [CNT_W-1:0] cap;
      units = bu ? nb : CNT_W'((nb + CNT_ONE) >> 1); // R4
      cap = cap_units(lim, bu);
      return (units < cap) ? units[WORD_W-1:0] : cap[WORD_W-1:0]; // R8
   endfunction
   logic [NCH-1:0] err_p;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_word <= '0;
         count_word <= '0;
         err_p <= '0;
      end else if (ce) begin
         for (int i = 0; i < NCH; i++) begin
            if (fin[i]) begin
               // Written in the finishing cycle, ahead of any scan end
               result_word[i] <= rej && iss_ch == 1'(i) ? g_code : RES_OK; // R2 R19 R22
               count_word[i] <= rej && iss_ch == 1'(i) ? RES_OK
                  : count_units(nb_now, allow[i], byte_units); // R3 R7 R8 R22
               err_p[i] <= rej && iss_ch == 1'(i);
            end
         end
      end
   end
   // ==========================================
   // Completion bits, paced by scan end
   ffrh_done_t st [NCH];
   logic [NCH-1:0] again;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NCH; i++) begin
            st[i] <= DS_IDLE;
         end
         again <= '0;
         completion_bit <= '0;
         completion_status <= '0;
      end else if (ce) begin
         for (int i = 0; i < NCH; i++) begin
            unique case (st[i])
               DS_IDLE: begin
                  if (fin[i]) begin
                     st[i] <= DS_PEND;
                  end
               end
               DS_PEND: begin
                  if (scan_end) begin
                     st[i] <= DS_SHOW;
                     completion_bit[i] <= 1'b1; // R17
                     completion_status[i] <= err_p[i]; // R18
                  end
               end
               DS_SHOW: begin
                  // A finish seen while showing is queued, never lost
                  if (scan_end) begin
                     st[i] <= (fin[i] || again[i]) ? DS_PEND : DS_IDLE;
                     again[i] <= 1'b0;
                     completion_bit[i] <= 1'b0; // R17
                     completion_status[i] <= 1'b0; // R18
                  end else if (fin[i]) begin
                     again[i] <= 1'b1;
                  end
               end
            endcase
         end
      end
   end
   // ==========================================
   // System error; a new error wins over a clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         system_error_flag <= 1'b0;
         system_error_code_word <= RES_OK;
      end else if (ce) begin
         if (op_issue && !chan_ok(op_chan)) begin
            system_error_flag <= 1'b1; // R20
            system_error_code_word <= ERR_CHAN; // R20
         end else if (sys_err_clr) begin
            system_error_flag <= 1'b0;
         end
      end
   end
   // ==========================================
   // Checks
   a_done_one_scan: assert property (@(posedge clk) disable iff (sys_rst) // R17
      (ce && completion_bit[0] && scan_end) |=> !completion_bit[0])
      else $error("completion bit held past one scan");
   a_done_at_scan: assert property (@(posedge clk) disable iff (sys_rst) // R17
      $rose(completion_bit[1]) |-> $past(scan_end) && $past(st[1]) == DS_PEND)
      else $error("completion bit rose away from a scan end");
   a_status_aligned: assert property (@(posedge clk) disable iff (sys_rst) // R18
      completion_status[0] |-> completion_bit[0])
      else $error("status bit without completion bit");
   a_status_code: assert property (@(posedge clk) disable iff (sys_rst) // R19
      completion_bit[0] |-> (completion_status[0] == (result_word[0] != RES_OK)))
      else $error("status bit and result word disagree");
   a_count_capped: assert property (@(posedge clk) disable iff (sys_rst) // R8
      completion_bit[0] |-> {1'b0, count_word[0]} <= cap_units(allow[0], byte_units))
      else $error("count above allowed size");
   a_write_bounded: assert property (@(posedge clk) disable iff (sys_rst) // R7
      (ce && wr_ev && woff[e_ch] >= {1'b0, allow[e_ch]}) |=> !dev_we)
      else $error("write beyond allowed size");
   a_words_early: assert property (@(posedge clk) disable iff (sys_rst) // R22
      $rose(completion_bit[0]) |-> $stable(result_word[0]) && $stable(count_word[0]))
      else $error("result changed with completion bit");
   a_channel_setting_op_conflict: assert property (@(posedge clk) disable iff (sys_rst) // R13
      (ce && iss_ok && op_kind == OP_CHAN_SET && act[iss_ch]) |=> op_ans_valid && op_ans_code == ERR_SIMUL)
      else $error("channel setting not refused during receive");
   a_proto_fail: assert property (@(posedge clk) disable iff (sys_rst) // R16
      (ce && rej && g_code == ERR_PROTO) |=> result_word[$past(iss_ch)] == ERR_PROTO)
      else $error("protocol error code not stored");
   a_sys_error: assert property (@(posedge clk) disable iff (sys_rst) // R20
      (ce && op_issue && !chan_ok(op_chan)) |=> system_error_flag && system_error_code_word == ERR_CHAN)
      else $error("system error not raised");
endmodule

/* File: ffrh_cpu_model.sv */
`timescale 1ns/1ns
// ==========================================
// Program side: scan timing and instruction issue
module ffrh_cpu_model
   import ffrh_pkg::*;
#(
   parameter int SCAN = 16
) (
   // Clock and completion view
   input logic clk,
   input logic [NCH-1:0] completion_bit,
   // Instruction lines
   output logic op_issue = 1'b0,
   output ffrh_op_t op_kind = OP_OTHER,
   output logic [WORD_W-1:0] op_chan = 16'h0000,
   output logic [WORD_W-1:0] op_allow = 16'h0001,
   output logic [WORD_W-1:0] op_head = 16'h0000,
   output logic op_end = 1'b0,
   output ffrh_op_t op_end_kind = OP_OTHER,
   output logic [WORD_W-1:0] op_end_chan = 16'h0000,
   // Scan end pulse
   output logic scan_end = 1'b0
);
   int t = 0;
   always @(negedge clk) begin
      t <= (t == SCAN - 1) ? 0 : t + 1;
      scan_end <= (t == SCAN - 1);
   end
   // One pulse per execution of a held command; never an interrupt buffer receive
   task automatic issue(input ffrh_op_t k, input logic [15:0] ch, input logic [15:0] al, input logic [15:0] hd);
      // Let an edge pass so a back-to-back issue never sees its strobe lowered and raised at once
      @(negedge clk);
      while (k == OP_RECEIVE && completion_bit !== 2'h0) @(negedge clk);
      op_issue = 1'b1;
      op_kind = (k == OP_BUF_RECV) ? OP_OTHER : k;
      op_chan = ch;
      op_allow = (al == 16'h0000) ? 16'h0001 : al;
      op_head = hd;
      @(negedge clk);
      op_issue = 1'b0;
   endtask
   task automatic finish(input ffrh_op_t k, input logic [15:0] ch);
      op_end = 1'b1;
      op_end_kind = k;
      op_end_chan = ch;
      @(negedge clk);
      op_end = 1'b0;
   endtask
endmodule

/* File: ffrh_test.sv */
`timescale 1ns/1ns
module ffrh_test;
   import ffrh_pkg::*;
   localparam int SCAN = 16;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic byte_units = 1'b0;
   logic sys_err_clr = 1'b0;
   logic rx_valid = 1'b0;
   logic [BYTE_W-1:0] rx_data = 8'h00;
   logic rx_chan = 1'b0;
   logic rx_last = 1'b0;
   logic dev_hold = 1'b0;
   logic op_issue, op_end, scan_end, op_ans_valid, rx_ready, dev_we, system_error_flag;
   ffrh_op_t op_kind, op_end_kind;
   logic [WORD_W-1:0] op_chan, op_allow, op_head, op_end_chan, op_ans_code, dev_addr, dev_data;
   logic [WORD_W-1:0] system_error_code_word;
   logic [NCH-1:0][WORD_W-1:0] result_word, count_word;
   logic [NCH-1:0] completion_bit, completion_status;
   int fails = 0;
   int checks = 0;
   logic [31:0] seed = 32'h0000_c84e;
   logic [31:0] wq[$];
   int nb[2];
   int al[2];
   logic [15:0] hd[2];
   logic [7:0] prv[2];
   ffrh_top #(.FIFO_DEPTH(8)) DUT (.clk, .sys_rst, .ce(1'b1), .op_issue, .op_kind, .op_chan, .op_allow,
      .op_head, .op_end, .op_end_kind, .op_end_chan, .op_ans_valid, .op_ans_code, .byte_units, .scan_end,
      .sys_err_clr, .rx_valid, .rx_data, .rx_chan, .rx_last, .rx_ready, .dev_hold, .dev_we, .dev_addr,
      .dev_data, .result_word, .count_word, .completion_bit, .completion_status, .system_error_flag,
      .system_error_code_word);
   ffrh_cpu_model #(.SCAN(SCAN)) cpu (.clk, .completion_bit, .op_issue, .op_kind, .op_chan, .op_allow,
      .op_head, .op_end, .op_end_kind, .op_end_chan, .scan_end);
   initial forever #20 clk = ~clk;
   // ==========================================
   // Shared tasks
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic setup(input int c, input int a);
      seed = lfsr(seed);
      nb[c] = 0;
      al[c] = a;
      hd[c] = seed[15:0];
   endtask
   // Caller lowers rx_valid after a burst, so data never changes twice in one step
   task automatic push(input int c, input logic lst);
      int w;
      seed = lfsr(seed);
      rx_valid = 1'b1;
      rx_data = seed[7:0];
      rx_chan = c[0];
      rx_last = lst;
      while (rx_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      w = nb[c] / 2;
      if ((nb[c] % 2 == 1 || lst) && w < al[c]) begin
         wq.push_back({hd[c] + 16'(w), (nb[c] % 2 == 1) ? {rx_data, prv[c]} : {8'h00, rx_data}});
      end
      prv[c] = rx_data;
      nb[c]++;
   endtask
   task automatic ans(input ffrh_op_t k, input int ch, input logic [15:0] code);
      cpu.issue(k, 16'(ch), 16'h0001, 16'h0000);
      chk("answer", {op_ans_valid, op_ans_code}, {1'b1, code});
   endtask
   task automatic done(input int c, input logic [15:0] res, input logic st);
      int n;
      int e;
      n = 0;
      e = byte_units ? nb[c] : (nb[c] + 1) / 2;
      if (e > (byte_units ? 2 * al[c] : al[c])) e = byte_units ? 2 * al[c] : al[c];
      while (completion_bit[c] !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk("result", result_word[c], res);
      chk("status", completion_status[c], st);
      if (!st) chk("count", count_word[c], e);
      n = 0;
      while (completion_bit[c] === 1'b1) begin
         @(negedge clk);
         n++;
      end
      chk("done span", n, SCAN);
      chk("pending writes", wq.size(), 0);
   endtask
   always @(negedge clk) begin
      if (dev_we === 1'b1) chk("write", {dev_addr, dev_data}, (wq.size() > 0) ? wq.pop_front() : 32'hffff_ffff);
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test;
   end
   // ==========================================
   // Scenarios
   initial begin
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      setup(0, 2);
      cpu.issue(OP_RECEIVE, CHAN_FIRST, 16'h0002, hd[0]);
      cpu.issue(OP_RECEIVE, CHAN_FIRST, 16'h0005, 16'h7000);
      ans(OP_CHAN_SET, 1, ERR_SIMUL);
      for (int k = 4; k < 8; k++) ans(ffrh_op_t'(k), 1, ERR_PROTO);
      ans(OP_CHAN_SET, 2, RES_OK);
      cpu.finish(OP_CHAN_SET, CHAN_SECOND);
      for (int i = 0; i < 5; i++) push(0, i == 4);
      rx_valid = 1'b0;
      done(0, RES_OK, 1'b0);
      $display("word truncation done");
      byte_units = 1'b1;
      setup(1, 1);
      cpu.issue(OP_RECEIVE, CHAN_SECOND, 16'h0001, hd[1]);
      dev_hold = 1'b1;
      // Eight entries of memory plus the output register stage
      repeat (9) push(1, 1'b0);
      chk("fifo full", rx_ready, 0);
      dev_hold = 1'b0;
      push(1, 1'b1);
      rx_valid = 1'b0;
      done(1, RES_OK, 1'b0);
      byte_units = 1'b0;
      $display("byte fill done");
      ans(OP_USER_REG, 2, RES_OK);
      cpu.issue(OP_RECEIVE, CHAN_SECOND, 16'h0001, 16'h0000);
      done(1, ERR_SIMUL, 1'b1);
      cpu.finish(OP_USER_REG, CHAN_SECOND);
      ans(OP_PROTOCOL, 2, RES_OK);
      cpu.issue(OP_RECEIVE, CHAN_SECOND, 16'h0001, 16'h0000);
      done(1, ERR_PROTO, 1'b1);
      cpu.finish(OP_PROTOCOL, CHAN_SECOND);
      setup(0, 1);
      cpu.issue(OP_RECEIVE, CHAN_FIRST, 16'h0001, hd[0]);
      ans(OP_USER_REG, 1, ERR_SIMUL);
      push(0, 1'b1);
      rx_valid = 1'b0;
      done(0, RES_OK, 1'b0);
      $display("overlap done");
      cpu.issue(OP_CHAN_SET, 16'h0003, 16'h0001, 16'h0000);
      chk("sys error", {op_ans_valid, system_error_flag, system_error_code_word}, {2'b01, ERR_CHAN_DEF});
      sys_err_clr = 1'b1;
      @(negedge clk);
      sys_err_clr = 1'b0;
      @(negedge clk);
      chk("sys error clear", system_error_flag, 0);
      $display("bad channel done");
      stop_test;
   end
endmodule
